// ===== pkg/cfg_link_pkg.sv
// constants and types shared by both ends of the configuration-register serial link
`default_nettype none
package cfg_link_pkg;
  // link addressing
  localparam logic [6:0] DEV_ADDR_DEF  = 7'h38;  // device address with select pins at 000
  localparam int         SEL_W         = 3;      // number of address-select pins
  localparam logic       DIR_READ      = 1'h1;   // direction bit value for a read cycle
  // command byte fields
  localparam logic [2:0] OP_WRITE      = 3'h3;   // write register
  localparam logic [2:0] OP_READ       = 3'h4;   // read register
  localparam int         OP_MSB        = 2;      // opcode in byte 0 bits 2:0
  localparam int         PSEL_HI_MSB   = 3;      // byte 1 bits 3:0 are port index 4:1
  localparam int         PSEL0_BIT     = 7;      // byte 2 bit 7 is port index 0
  localparam int         BE_MSB        = 5;      // byte 2 bits 5:2 are byte enables
  localparam int         BE_LSB        = 2;
  localparam int         AHI_MSB       = 1;      // byte 2 bits 1:0 are address 11:10
  localparam int         CMD_BYTES     = 4;      // command bytes per packet
  localparam int         PKT_BYTES     = 8;      // command plus write data bytes
  // controller register offsets and reset values
  localparam logic [7:0] CTL_CMD_OFS   = 8'h00;  // write starts a transfer
  localparam logic [7:0] CTL_WDATA_OFS = 8'h04;  // data for a write transfer
  localparam logic [7:0] CTL_RDATA_OFS = 8'h08;  // data returned by a read transfer
  localparam logic [7:0] CTL_STAT_OFS  = 8'h0c;  // bit0 busy, bit1 no acknowledge
  localparam logic [7:0] CTL_SADDR_OFS = 8'h10;  // target device address
  localparam logic [31:0] WORD_RST     = 32'h0000_0000;
  // timing
  localparam int CLK_PERIOD_NS = 25;     // core clock 40 MHz
  localparam int SCL_PERIOD_NS = 10000;  // 100 kHz link clock
  localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);  // rounded down
  // device state machine
  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_ADDR  = 3'h1,
    D_RX    = 3'h3,
    D_ACK   = 3'h2,
    D_TX    = 3'h6,
    D_TXACK = 3'h7
  } dev_st_e;
  // controller state machine
  typedef enum logic [1:0] {
    M_IDLE  = 2'h0,
    M_START = 2'h1,
    M_BIT   = 2'h3,
    M_STOP  = 2'h2
  } mst_st_e;
  // port indices that reach a real port
  function automatic logic port_ok(input logic [4:0] p);
    port_ok = (p == 5'h00) || (p == 5'h02) || (p == 5'h03) || (p >= 5'h0a && p <= 5'h0f);
  endfunction
endpackage
`default_nettype wire

// ===== pkg/cfg_link_if.sv
// two-wire open-drain link between controller and device
`default_nettype none
interface cfg_link_if;
  logic m_scl_out;   // controller clock drive value
  logic m_scl_oe_n;  // controller clock enable, low drives
  logic m_sda_out;   // controller data drive value
  logic m_sda_oe_n;  // controller data enable, low drives
  logic s_sda_out;   // device data drive value
  logic s_sda_oe_n;  // device data enable, low drives
  logic scl;         // resolved clock wire
  logic sda;         // resolved data wire
  // wired-and with pull-ups
  assign scl = m_scl_oe_n | m_scl_out;
  assign sda = (m_sda_oe_n | m_sda_out) & (s_sda_oe_n | s_sda_out);
  modport ctl (output m_scl_out, m_scl_oe_n, m_sda_out, m_sda_oe_n, input scl, sda);
  modport dev (output s_sda_out, s_sda_oe_n, input scl, sda);
endinterface
`default_nettype wire

// ===== verilog/cfg_dev.sv
// device end: serial slave that reads and writes configuration registers
// Contract
// RULE_01 - opcode 011b in byte 0 requests write
// RULE_02 - opcode 100b in byte 0 requests read
// RULE_03 - master reads via command packet then data packet
// RULE_04 - direction bit one means read cycle
// RULE_05 - read command loads register into buffer
// RULE_06 - buffer sent most significant byte first
// RULE_07 - beyond four bytes, sequence repeats from top
// RULE_08 - repeated start merges packets; both forms accepted
// RULE_09 - port index from byte1[3:0] and byte2[7]
// RULE_10 - only listed port indices are valid
// RULE_11 - byte2[5:2] enable register bytes for writing
// RULE_12 - word address from byte2[1:0] and byte3
// RULE_13 - write data byte 3 first, then stop
// RULE_14 - address 38h with select pins 000
// RULE_15 - ack all own bytes; ignore bad commands
// RULE_16 - master drives reserved bits as zero; controller sends command bits as written to the command register
`default_nettype none
module cfg_dev (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESETN,
  // link
  cfg_link_if.dev                BUS,
  // address-select pins
  input  wire logic [2:0]        ADDR_SEL,
  // register access port
  output logic                   REG_RD,
  output logic                   REG_WR,
  output logic [4:0]             REG_PORT,
  output logic [11:0]            REG_ADDR,
  output logic [3:0]             REG_BE,
  output logic [31:0]            REG_WDATA,
  input  wire logic [31:0]       REG_RDATA
);
  import cfg_link_pkg::*;

  // whole state of the device end
  typedef struct packed {
    logic [2:0]  scl_p;    // [0],[1] synchroniser, [2] delayed copy
    logic [2:0]  sda_p;    // same for data
    logic [2:0]  sel_s1;   // select pins, first stage
    logic [2:0]  sel_s2;   // select pins, second stage
    dev_st_e     st;       // link state
    logic [3:0]  bitc;     // bits done in current byte
    logic [7:0]  sh;       // shift register
    logic        rw;       // direction of current cycle
    logic [3:0]  byc;      // bytes received in packet
    logic [7:0]  op_b;     // command byte 0
    logic [4:0]  port;     // target port index
    logic [3:0]  be;       // byte enables
    logic [11:0] addr;     // register byte address
    logic [31:0] wd;       // write data
    logic [31:0] rbuf;     // read buffer
    logic [1:0]  txi;      // next buffer byte to send
    logic        mack;     // master acknowledged last byte
    logic        rd_wait;  // read data due this cycle
    logic        sda_oe_n; // data drive enable
    logic        rd;       // read strobe
    logic        wr;       // write strobe
  } dev_s;

  dev_s r_reg;   // registered state
  dev_s r_next;  // next state

  // byte of the buffer selected for sending
  function automatic logic [7:0] buf_byte(input logic [31:0] b, input logic [1:0] i);
    buf_byte = b[8'(31 - 8 * int'(i)) -: 8];  // RULE_06
  endfunction

  logic scl_rise;   // link clock rose
  logic scl_fall;   // link clock fell
  logic sda_now;    // synchronised data
  logic start_c;    // start or repeated start seen
  logic stop_c;     // stop seen
  logic [6:0] my_addr;  // own link address
  logic [7:0] tx_b;     // byte about to be sent

  // link events from synchronised wires
  always_comb begin
    sda_now  = r_reg.sda_p[1];
    scl_rise = r_reg.scl_p[1] & ~r_reg.scl_p[2];
    scl_fall = ~r_reg.scl_p[1] & r_reg.scl_p[2];
    start_c  = r_reg.scl_p[1] & r_reg.scl_p[2] & ~r_reg.sda_p[1] & r_reg.sda_p[2];
    stop_c   = r_reg.scl_p[1] & r_reg.scl_p[2] & r_reg.sda_p[1] & ~r_reg.sda_p[2];
    my_addr  = {DEV_ADDR_DEF[6:SEL_W], r_reg.sel_s2};  // RULE_14
    tx_b     = buf_byte(r_reg.rbuf, r_reg.txi);
  end

  // next-state logic
  always_comb begin
    r_next       = r_reg;
    r_next.rd    = 1'b0;
    r_next.wr    = 1'b0;
    r_next.scl_p = {r_reg.scl_p[1:0], BUS.scl};
    r_next.sda_p = {r_reg.sda_p[1:0], BUS.sda};
    r_next.sel_s1 = ADDR_SEL;
    r_next.sel_s2 = r_reg.sel_s1;
    // capture register contents in the read strobe cycle
    if (r_reg.rd_wait) begin
      r_next.rbuf    = REG_RDATA;  // RULE_05
      r_next.rd_wait = 1'b0;
    end
    if (start_c) begin
      // start or repeated start; command and buffer are kept
      r_next.st       = D_ADDR;  // RULE_08
      r_next.bitc     = 4'h0;
      r_next.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      // stop ends any cycle
      r_next.st       = D_IDLE;
      r_next.sda_oe_n = 1'b1;
    end else begin
      case (r_reg.st)
        D_ADDR, D_RX: begin
          if (scl_rise && r_reg.bitc != 4'h8) begin
            // sample one bit
            r_next.sh   = {r_reg.sh[6:0], sda_now};
            r_next.bitc = r_reg.bitc + 4'h1;
          end else if (scl_fall && r_reg.bitc == 4'h8) begin
            if (r_reg.st == D_ADDR) begin
              if (r_reg.sh[7:1] == my_addr) begin
                // address matched: acknowledge
                r_next.rw       = r_reg.sh[0];  // RULE_04
                r_next.sda_oe_n = 1'b0;  // RULE_15
                r_next.st       = D_ACK;
                r_next.txi      = 2'h0;
                if (r_reg.sh[0] != DIR_READ) begin
                  r_next.byc = 4'h0;
                end
              end else begin
                // other device addressed
                r_next.st = D_IDLE;
              end
            end else begin
              // command or data byte received: acknowledge
              r_next.sda_oe_n = 1'b0;  // RULE_15
              r_next.st       = D_ACK;
              if (r_reg.byc != 4'(PKT_BYTES)) begin
                r_next.byc = r_reg.byc + 4'h1;
              end
              case (r_reg.byc)
                4'h0: r_next.op_b = r_reg.sh;  // RULE_01 RULE_02
                4'h1: r_next.port[4:1] = r_reg.sh[PSEL_HI_MSB:0];  // RULE_09
                4'h2: begin
                  r_next.port[0]    = r_reg.sh[PSEL0_BIT];  // RULE_09
                  r_next.be         = r_reg.sh[BE_MSB:BE_LSB];  // RULE_11
                  r_next.addr[11:10] = r_reg.sh[AHI_MSB:0];  // RULE_12
                end
                4'h3: begin
                  r_next.addr[9:2] = r_reg.sh;  // RULE_12
                  r_next.addr[1:0] = 2'h0;  // RULE_12
                  // read command fetches the word now
                  if (r_reg.op_b[OP_MSB:0] == OP_READ && port_ok(r_reg.port)) begin  // RULE_10
                    r_next.rd      = 1'b1;  // RULE_02 RULE_05
                    r_next.rd_wait = 1'b1;
                  end
                end
                4'h4, 4'h5, 4'h6, 4'h7: begin
                  r_next.wd = {r_reg.wd[23:0], r_reg.sh};  // RULE_13
                  if (r_reg.byc == 4'(PKT_BYTES - 1) && r_reg.op_b[OP_MSB:0] == OP_WRITE
                      && port_ok(r_reg.port)) begin  // RULE_10 RULE_15
                    r_next.wr = 1'b1;  // RULE_01
                  end
                end
                default: ;  // surplus bytes acknowledged and dropped
              endcase
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            if (r_reg.rw == DIR_READ) begin
              // first bit of the first buffer byte
              r_next.sh       = {tx_b[6:0], 1'b0};
              r_next.sda_oe_n = tx_b[7];  // RULE_06
              r_next.bitc     = 4'h1;
              r_next.st       = D_TX;
            end else begin
              r_next.sda_oe_n = 1'b1;
              r_next.bitc     = 4'h0;
              r_next.st       = D_RX;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (r_reg.bitc == 4'h8) begin
              // byte sent: free the wire for the master's answer
              r_next.sda_oe_n = 1'b1;
              r_next.st       = D_TXACK;
              r_next.txi      = r_reg.txi + 2'h1;  // RULE_07
            end else begin
              r_next.sda_oe_n = r_reg.sh[7];
              r_next.sh       = {r_reg.sh[6:0], 1'b0};
              r_next.bitc     = r_reg.bitc + 4'h1;
            end
          end
        end
        D_TXACK: begin
          if (scl_rise) begin
            r_next.mack = ~sda_now;
          end else if (scl_fall) begin
            if (r_reg.mack) begin
              // next byte, wrapping to the top byte after the fourth
              r_next.sh       = {tx_b[6:0], 1'b0};
              r_next.sda_oe_n = tx_b[7];  // RULE_06 RULE_07
              r_next.bitc     = 4'h1;
              r_next.st       = D_TX;
            end else begin
              r_next.st = D_IDLE;
            end
          end
        end
        D_IDLE: ;  // wait for a start
        default: r_next.st = D_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      r_reg          <= '0;
      r_reg.scl_p    <= 3'h7;
      r_reg.sda_p    <= 3'h7;
      r_reg.sda_oe_n <= 1'b1;
      r_reg.st       <= D_IDLE;
      r_reg.rbuf     <= WORD_RST;
      r_reg.wd       <= WORD_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from state
  assign BUS.s_sda_out  = 1'b0;
  assign BUS.s_sda_oe_n = r_reg.sda_oe_n;
  assign REG_RD         = r_reg.rd;
  assign REG_WR         = r_reg.wr;
  assign REG_PORT       = r_reg.port;
  assign REG_ADDR       = r_reg.addr;
  assign REG_BE         = r_reg.be;
  assign REG_WDATA      = r_reg.wd;
endmodule
`default_nettype wire

// ===== verilog/cfg_ctl.sv
// controller end: link master driven by a small register port
`default_nettype none
module cfg_ctl (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // link
  cfg_link_if.ctl          BUS,
  // software register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA
);
  import cfg_link_pkg::*;

  // whole state of the controller end
  typedef struct packed {
    logic        scl_oe_n;  // clock drive enable
    logic        sda_oe_n;  // data drive enable
    logic        sda_s1;    // data synchroniser first stage
    logic        sda_s2;    // data synchroniser second stage
    logic [6:0]  qcnt;      // quarter-period divider
    mst_st_e     st;        // sequence state
    logic [1:0]  ph;        // quarter of the current bit
    logic [3:0]  bitc;      // bit in byte, 8 is the answer bit
    logic [3:0]  bi;        // byte index in the transfer
    logic [7:0]  sh;        // shift register
    logic [31:0] cmd;       // four command bytes, byte 0 low
    logic [31:0] wd;        // write data
    logic [31:0] rd_data;   // read data
    logic [6:0]  saddr;     // target address
    logic        busy;      // transfer running
    logic        nack;      // no acknowledge seen
    logic [31:0] rdo;       // read port data
  } ctl_s;

  ctl_s r_reg;   // registered state
  ctl_s r_next;  // next state

  // byte sent at a given index of the transfer
  function automatic logic [7:0] tx_byte(input ctl_s s, input logic [3:0] i);
    if (i == 4'h0) begin
      tx_byte = {s.saddr, 1'b0};
    end else if (i <= 4'(CMD_BYTES)) begin
      tx_byte = s.cmd[8'(8 * int'(i) - 1) -: 8];
    end else if (s.cmd[OP_MSB:0] == OP_READ) begin
      tx_byte = {s.saddr, DIR_READ};  // RULE_08
    end else begin
      tx_byte = s.wd[8'(71 - 8 * int'(i)) -: 8];  // RULE_13
    end
  endfunction

  logic tick;     // quarter-period enable
  logic is_rd;    // transfer is a register read
  logic wr_byte;  // current byte is sent by us

  // decode of the current transfer
  always_comb begin
    tick    = r_reg.busy && r_reg.qcnt == 7'(QTR_CYC - 1);
    is_rd   = r_reg.cmd[OP_MSB:0] == OP_READ;
    wr_byte = !(is_rd && r_reg.bi > 4'h5);
  end

  // next-state logic
  always_comb begin
    r_next        = r_reg;
    r_next.sda_s1 = BUS.sda;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.qcnt   = (tick || !r_reg.busy) ? 7'h0 : r_reg.qcnt + 7'h1;
    // software port
    r_next.rdo = WORD_RST;
    if (RD) begin
      case (ADDR)
        CTL_CMD_OFS:   r_next.rdo = r_reg.cmd;
        CTL_WDATA_OFS: r_next.rdo = r_reg.wd;
        CTL_RDATA_OFS: r_next.rdo = r_reg.rd_data;
        CTL_STAT_OFS:  r_next.rdo = {30'h0, r_reg.nack, r_reg.busy};
        CTL_SADDR_OFS: r_next.rdo = {25'h0, r_reg.saddr};
        default:       r_next.rdo = WORD_RST;
      endcase
    end
    if (WR) begin
      case (ADDR)
        CTL_WDATA_OFS: r_next.wd = WDATA;
        CTL_SADDR_OFS: r_next.saddr = WDATA[6:0];
        CTL_CMD_OFS: begin
          // start a transfer unless one is running
          if (!r_reg.busy) begin
            r_next.cmd  = WDATA;  // RULE_16
            r_next.busy = 1'b1;
            r_next.nack = 1'b0;
            r_next.st   = M_START;
            r_next.ph   = 2'h0;
            r_next.bi   = 4'h0;
          end
        end
        default: ;  // unmapped write ignored
      endcase
    end
    if (tick) begin
      r_next.ph = r_reg.ph + 2'h1;
      case (r_reg.st)
        M_START: begin
          // start or repeated start
          case (r_reg.ph)
            2'h0: r_next.sda_oe_n = 1'b1;
            2'h1: r_next.scl_oe_n = 1'b1;
            2'h2: r_next.sda_oe_n = 1'b0;
            default: begin
              r_next.scl_oe_n = 1'b0;
              r_next.st       = M_BIT;
              r_next.bitc     = 4'h0;
              r_next.sh       = tx_byte(r_reg, r_reg.bi);
            end
          endcase
        end
        M_BIT: begin
          case (r_reg.ph)
            2'h0: begin
              if (r_reg.bitc != 4'h8) begin
                r_next.sda_oe_n = wr_byte ? r_reg.sh[7] : 1'b1;
              end else begin
                // answer bit: ack each read byte but the last
                r_next.sda_oe_n = wr_byte ? 1'b1 : (r_reg.bi == 4'h9);
              end
            end
            2'h1: r_next.scl_oe_n = 1'b1;
            2'h2: begin
              if (r_reg.bitc != 4'h8) begin
                r_next.sh = {r_reg.sh[6:0], r_reg.sda_s2};
              end else if (wr_byte && r_reg.sda_s2) begin
                r_next.nack = 1'b1;
              end
            end
            default: begin
              r_next.scl_oe_n = 1'b0;
              if (r_reg.bitc != 4'h8) begin
                r_next.bitc = r_reg.bitc + 4'h1;
              end else begin
                if (!wr_byte) begin
                  r_next.rd_data = {r_reg.rd_data[23:0], r_reg.sh};  // RULE_06
                end
                r_next.bitc = 4'h0;
                if (r_reg.nack || (!is_rd && r_reg.bi == 4'h8) || r_reg.bi == 4'h9) begin
                  r_next.st = M_STOP;  // RULE_13
                end else if (is_rd && r_reg.bi == 4'h4) begin
                  r_next.st = M_START;  // RULE_03 RULE_08
                  r_next.bi = 4'h5;
                end else begin
                  r_next.bi = r_reg.bi + 4'h1;
                  r_next.sh = tx_byte(r_reg, r_reg.bi + 4'h1);
                end
              end
            end
          endcase
        end
        M_STOP: begin
          case (r_reg.ph)
            2'h0: r_next.sda_oe_n = 1'b0;
            2'h1: r_next.scl_oe_n = 1'b1;
            2'h2: r_next.sda_oe_n = 1'b1;
            default: begin
              r_next.st   = M_IDLE;
              r_next.busy = 1'b0;
            end
          endcase
        end
        M_IDLE: ;  // nothing to do
        default: r_next.st = M_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      r_reg          <= '0;
      r_reg.scl_oe_n <= 1'b1;
      r_reg.sda_oe_n <= 1'b1;
      r_reg.sda_s1   <= 1'b1;
      r_reg.sda_s2   <= 1'b1;
      r_reg.st       <= M_IDLE;
      r_reg.saddr    <= DEV_ADDR_DEF;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from state
  assign BUS.m_scl_out  = 1'b0;
  assign BUS.m_scl_oe_n = r_reg.scl_oe_n;
  assign BUS.m_sda_out  = 1'b0;
  assign BUS.m_sda_oe_n = r_reg.sda_oe_n;
  assign RDATA          = r_reg.rdo;
endmodule
`default_nettype wire

// ===== sim/cfg_link_properties.sv
// link and register-strobe assertions for the configuration serial link
`default_nettype none
module cfg_link_properties (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // link signals
  input wire logic        m_scl_out,
  input wire logic        m_sda_out,
  input wire logic        s_sda_out,
  input wire logic        s_sda_oe_n,
  input wire logic        scl,
  input wire logic        sda,
  // device register strobes
  input wire logic        REG_RD,
  input wire logic        REG_WR,
  input wire logic [4:0]  REG_PORT,
  input wire logic [11:0] REG_ADDR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // a strobe is a single pulse followed by a quiet span
  sequence wr_once_s;
    REG_WR ##1 !REG_WR [*8];
  endsequence
  sequence rd_once_s;
    REG_RD ##1 !REG_RD [*8];
  endsequence
  // open drain: drive values only ever pull low
  open_drain_a: assert property (!m_scl_out && !m_sda_out && !s_sda_out)
    else $error("drive value not low");
  rd_wr_excl_a: assert property (!(REG_RD && REG_WR))
    else $error("read and write strobes together");
  wr_pulse_a: assert property (REG_WR |-> wr_once_s)
    else $error("write strobe not a single pulse");
  rd_pulse_a: assert property (REG_RD |-> rd_once_s)
    else $error("read strobe not a single pulse");
  addr_align_a: assert property ((REG_RD || REG_WR) |-> REG_ADDR[1:0] == 2'h0)
    else $error("word address low bits not zero");
  port_valid_a: assert property ((REG_RD || REG_WR) |->
      REG_PORT inside {5'h00, 5'h02, 5'h03, [5'h0a:5'h0f]})
    else $error("access to reserved port index");
  strobe_scl_low_a: assert property ((REG_RD || REG_WR) |-> !scl)
    else $error("strobe outside acknowledge low phase");
  dev_sda_stable_a: assert property ((scl && $past(scl)) |-> $stable(s_sda_oe_n))
    else $error("device data changed while clock high");
  // the byte that triggers a register access is being acknowledged
  ack_low_a: assert property ((REG_RD || REG_WR) |-> !s_sda_oe_n && !sda)
    else $error("register access without acknowledge");
endmodule
`default_nettype wire

// ===== sim/test_i2c_config_register_access.sv
// self-checking bench joining controller and device over the serial link
`default_nettype none
module test_i2c_config_register_access;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_link_pkg::*;
  localparam logic [31:0] RD_VAL = 32'hc3a5_1e0f;  // register value, distinct bytes
  logic        clk = 1'b0;      // core clock
  logic        resetn = 1'b0;   // async reset, low active
  logic [7:0]  addr = 8'h00;    // software port
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [2:0]  addr_sel = 3'h0; // device address select pins
  logic        reg_rd;          // device register port
  logic        reg_wr;
  logic [4:0]  reg_port;
  logic [11:0] reg_addr;
  logic [3:0]  reg_be;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata = RD_VAL;  // register contents, cleared once fetched
  logic [31:0] cap_w;           // captured register access
  logic [4:0]  cap_p;
  logic [11:0] cap_a;
  logic [3:0]  cap_b;
  logic [31:0] got;
  int          fail_count = 0;
  int          n_tests = 0;
  int          wr_cnt = 0;
  int          rd_cnt = 0;
  cfg_link_if link ();
  cfg_ctl u_cfg_ctl (.CLK(clk), .RESETN(resetn), .BUS(link), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata));
  cfg_dev u_cfg_dev (.CLK(clk), .RESETN(resetn), .BUS(link), .ADDR_SEL(addr_sel),
    .REG_RD(reg_rd), .REG_WR(reg_wr), .REG_PORT(reg_port), .REG_ADDR(reg_addr),
    .REG_BE(reg_be), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));
  cfg_link_properties u_cfg_link_properties (.CLK(clk), .RESETN(resetn),
    .m_scl_out(link.m_scl_out), .m_sda_out(link.m_sda_out), .s_sda_out(link.s_sda_out),
    .s_sda_oe_n(link.s_sda_oe_n), .scl(link.scl), .sda(link.sda), .REG_RD(reg_rd),
    .REG_WR(reg_wr), .REG_PORT(reg_port), .REG_ADDR(reg_addr));
  // clock generator
  always #12.5 clk = ~clk;
  // register side of the device: record accesses, contents valid in the strobe cycle
  always @(posedge clk) begin
    if (reg_wr === 1'b1) begin
      wr_cnt++;
      cap_w <= reg_wdata;
      cap_b <= reg_be;
      cap_p <= reg_port;
      cap_a <= reg_addr;
    end
    if (reg_rd === 1'b1) begin
      rd_cnt++;
      cap_p <= reg_port;
      cap_a <= reg_addr;
      reg_rdata <= 32'h0;  // a late capture would see zero
    end
  end
  // compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // software write strobe
  task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // software read strobe, data taken in the following cycle
  task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // start a transfer and poll status until idle
  task automatic run(input logic [31:0] cmd, input logic [31:0] wd, input logic [31:0] st);
    logic [31:0] s;
    sw_wr(CTL_WDATA_OFS, wd);
    sw_wr(CTL_CMD_OFS, cmd);
    s = 32'h1;
    for (int i = 0; i < 30000 && s[0] !== 1'b0; i++) sw_rd(CTL_STAT_OFS, s);
    chk("status", st, s);
  endtask
  // verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (120000) @(posedge clk);  // about 108k cycles of link traffic plus margin
    fail_count++;
    $display("timeout");
    end_sim;
  end
  // test sequence
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    // controller target address out of reset
    sw_rd(CTL_SADDR_OFS, got);
    chk("target addr", {25'h0, DEV_ADDR_DEF}, got);
    // write, port 0, word f8h, enables for bytes 0 and 2 only
    run(32'h3e14_0003, 32'h1234_5678, 32'h0);
    chk("write count", 32'd1, 32'(wr_cnt));
    chk("write data", 32'h1234_5678, cap_w);
    chk("byte enables", 32'h5, {28'h0, cap_b});
    chk("write port", 32'h0, {27'h0, cap_p});
    chk("write addr", 32'h0f8, {20'h0, cap_a});
    $display("test write done");
    // merged read, port 0bh, word 954h
    run(32'h559a_0504, 32'h0, 32'h0);
    sw_rd(CTL_RDATA_OFS, got);
    chk("read data", RD_VAL, got);
    chk("read count", 32'd1, 32'(rd_cnt));
    chk("read port", 32'h0b, {27'h0, cap_p});
    chk("read addr", 32'h954, {20'h0, cap_a});
    chk("no write on read", 32'd1, 32'(wr_cnt));
    $display("test read done");
    // reserved port index 05h: bytes acked, no register access
    run(32'h01bc_0203, 32'hffff_ffff, 32'h0);
    chk("reserved port", 32'd1, 32'(wr_cnt));
    $display("test reserved port done");
    // select pins move the device off address 38h
    @(posedge clk);
    addr_sel <= 3'h1;
    repeat (4) @(posedge clk);
    run(32'h3e3c_0003, 32'h0, 32'h2);
    chk("no access", 32'd1, 32'(wr_cnt));
    $display("test address select done");
    end_sim;
  end
endmodule
`default_nettype wire
